// ---- dpd_primary_dither.sv ----
`timescale 1ns/1ns
module dpd_primary_dither (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic regWrEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   input wire logic [23:0] leftModIn,
   input wire logic [23:0] rightModIn,
   output logic [23:0] leftModOut,
   output logic [23:0] rightModOut,
   output logic [1:0] leftAcGain,
   output logic [1:0] rightAcGain,
   output logic [1:0] leftMatchGain,
   output logic [1:0] rightMatchGain
);
   logic [7:0] gains_ff;
   logic [2:0] leftHigh_ff;
   logic [7:0] leftLow_ff;
   logic [2:0] rightHigh_ff;
   logic [7:0] rightLow_ff;
   logic [7:0] regRdData_ff;
   logic [7:0] nxt_rdData;
   logic selGains, selLh, selLl, selRh, selRl;
   dpd_chan_if leftIf ();
   dpd_chan_if rightIf ();

   assign selGains = regAddr == dpd_pkg::AddrGains;
   assign selLh = regAddr == dpd_pkg::AddrLeftDcHigh;
   assign selLl = regAddr == dpd_pkg::AddrLeftDcLow;
   assign selRh = regAddr == dpd_pkg::AddrRightDcHigh;
   assign selRl = regAddr == dpd_pkg::AddrRightDcLow;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gains_ff <= dpd_pkg::ResetGains;
         leftHigh_ff <= dpd_pkg::ResetDc[2:0];
         leftLow_ff <= dpd_pkg::ResetDc;
         rightHigh_ff <= dpd_pkg::ResetDc[2:0];
         rightLow_ff <= dpd_pkg::ResetDc;
      end else if (regWrEn) begin
         // reserved matching codes are stored as written; host keeps them out
         if (selGains) gains_ff <= regWrData;
         if (selLh) leftHigh_ff <= regWrData[2:0];
         if (selLl) leftLow_ff <= regWrData;
         if (selRh) rightHigh_ff <= regWrData[2:0];
         if (selRl) rightLow_ff <= regWrData;
      end
   end

   // reserved high bits read as zero
   assign nxt_rdData = selGains ? gains_ff :
                       selLh ? {5'h00, leftHigh_ff} :
                       selLl ? leftLow_ff :
                       selRh ? {5'h00, rightHigh_ff} :
                       selRl ? rightLow_ff : 8'h00;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdData_ff <= 8'h00;
      end else begin
         regRdData_ff <= nxt_rdData;
      end
   end
   assign regRdData = regRdData_ff;

   assign leftIf.acGain = gains_ff[dpd_pkg::LeftAcPos +: 2];
   assign rightIf.acGain = gains_ff[dpd_pkg::RightAcPos +: 2];
   assign leftIf.matchGain = gains_ff[dpd_pkg::LeftMatchPos +: 2];
   assign rightIf.matchGain = gains_ff[dpd_pkg::RightMatchPos +: 2];
   assign leftIf.dcValue = {leftHigh_ff, leftLow_ff};
   assign rightIf.dcValue = {rightHigh_ff, rightLow_ff};
   assign leftIf.modIn = leftModIn;
   assign rightIf.modIn = rightModIn;

   dpd_chan_inject uLeft (.clk(clk), .arst_n(arst_n), .ch(leftIf));
   dpd_chan_inject uRight (.clk(clk), .arst_n(arst_n), .ch(rightIf));

   assign leftModOut = leftIf.modOut;
   assign rightModOut = rightIf.modOut;
   assign leftAcGain = gains_ff[dpd_pkg::LeftAcPos +: 2];
   assign rightAcGain = gains_ff[dpd_pkg::RightAcPos +: 2];
   assign leftMatchGain = gains_ff[dpd_pkg::LeftMatchPos +: 2];
   assign rightMatchGain = gains_ff[dpd_pkg::RightMatchPos +: 2];

   // first edge after reset has no valid history for the path checks
   logic runOk_ff;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         runOk_ff <= 1'b0;
      end else begin
         runOk_ff <= 1'b1;
      end
   end

   a_left_dc_add: assert property (@(posedge clk) disable iff (!arst_n)
      runOk_ff |->
      leftModOut == $past(leftModIn) + 24'($past(leftIf.dcValue) << dpd_pkg::DcLsbPos))
      else $error("left dc dither sum wrong");
   a_right_dc_add: assert property (@(posedge clk) disable iff (!arst_n)
      runOk_ff |->
      rightModOut == $past(rightModIn) + 24'($past(rightIf.dcValue) << dpd_pkg::DcLsbPos))
      else $error("right dc dither sum wrong");
   a_zero_dc_pass: assert property (@(posedge clk) disable iff (!arst_n)
      runOk_ff && $past(leftIf.dcValue) == 11'h000 |-> leftModOut == $past(leftModIn))
      else $error("zero dc dither changed path");
   a_dc_lsb_weight: assert property (@(posedge clk) disable iff (!arst_n)
      runOk_ff && $past(leftIf.dcValue) == 11'h001 |->
      leftModOut - $past(leftModIn) == 24'h000080)
      else $error("dc lsb weight wrong");

   // right channel path, same weighting as the left
   a_right_zero_pass: assert property (@(posedge clk) disable iff (!arst_n)
      runOk_ff && $past(rightIf.dcValue) == 11'h000 |-> rightModOut == $past(rightModIn))
      else $error("right zero dc dither changed path");

   a_right_lsb_weight: assert property (@(posedge clk) disable iff (!arst_n)
      runOk_ff && $past(rightIf.dcValue) == 11'h001 |->
      rightModOut - $past(rightModIn) == 24'h000080)
      else $error("right dc lsb weight wrong");

   // top bit of the value is 2^-1 of 1/32 full scale
   a_left_top_weight: assert property (@(posedge clk) disable iff (!arst_n)
      runOk_ff && $past(leftIf.dcValue) == 11'h400 |->
      leftModOut - $past(leftModIn) == 24'h020000)
      else $error("left dc top bit weight wrong");

   a_right_top_weight: assert property (@(posedge clk) disable iff (!arst_n)
      runOk_ff && $past(rightIf.dcValue) == 11'h400 |->
      rightModOut - $past(rightModIn) == 24'h020000)
      else $error("right dc top bit weight wrong");

   a_left_max_dc: assert property (@(posedge clk) disable iff (!arst_n)
      runOk_ff && $past(leftIf.dcValue) == 11'h7ff |->
      leftModOut - $past(leftModIn) == 24'h03ff80)
      else $error("left dc full value wrong");

   a_right_max_dc: assert property (@(posedge clk) disable iff (!arst_n)
      runOk_ff && $past(rightIf.dcValue) == 11'h7ff |->
      rightModOut - $past(rightModIn) == 24'h03ff80)
      else $error("right dc full value wrong");

   // dither never reaches below its lsb
   a_left_low_pass: assert property (@(posedge clk) disable iff (!arst_n)
      runOk_ff |->
      leftModOut[dpd_pkg::DcLsbPos-1:0] == $past(leftModIn[dpd_pkg::DcLsbPos-1:0]))
      else $error("left low path bits disturbed");

   a_right_low_pass: assert property (@(posedge clk) disable iff (!arst_n)
      runOk_ff |->
      rightModOut[dpd_pkg::DcLsbPos-1:0] == $past(rightModIn[dpd_pkg::DcLsbPos-1:0]))
      else $error("right low path bits disturbed");

   a_left_dc_join: assert property (@(posedge clk) disable iff (!arst_n)
      leftIf.dcValue == {leftHigh_ff, leftLow_ff})
      else $error("left dc value not joined");

   a_right_dc_join: assert property (@(posedge clk) disable iff (!arst_n)
      rightIf.dcValue == {rightHigh_ff, rightLow_ff})
      else $error("right dc value not joined");

   // gain fields seen by each channel match the pins
   a_left_ac_route: assert property (@(posedge clk) disable iff (!arst_n)
      leftIf.acGain == leftAcGain)
      else $error("left ac gain routing wrong");

   a_right_ac_route: assert property (@(posedge clk) disable iff (!arst_n)
      rightIf.acGain == rightAcGain)
      else $error("right ac gain routing wrong");

   a_left_match_route: assert property (@(posedge clk) disable iff (!arst_n)
      leftIf.matchGain == leftMatchGain)
      else $error("left matching gain routing wrong");

   a_right_match_route: assert property (@(posedge clk) disable iff (!arst_n)
      rightIf.matchGain == rightMatchGain)
      else $error("right matching gain routing wrong");

   a_left_ac_field: assert property (@(posedge clk) disable iff (!arst_n)
      leftAcGain == gains_ff[7:6])
      else $error("left ac gain field position wrong");

   a_right_ac_field: assert property (@(posedge clk) disable iff (!arst_n)
      rightAcGain == gains_ff[5:4])
      else $error("right ac gain field position wrong");

   a_left_match_field: assert property (@(posedge clk) disable iff (!arst_n)
      leftMatchGain == gains_ff[3:2])
      else $error("left matching field position wrong");

   a_right_match_field: assert property (@(posedge clk) disable iff (!arst_n)
      rightMatchGain == gains_ff[1:0])
      else $error("right matching field position wrong");

   // read path: one cycle behind the address
   a_rd_gains: assert property (@(posedge clk) disable iff (!arst_n)
      selGains |=> regRdData == $past(gains_ff))
      else $error("gains read back wrong");

   a_rd_left_high: assert property (@(posedge clk) disable iff (!arst_n)
      selLh |=> regRdData == {5'h00, $past(leftHigh_ff)})
      else $error("left dc high read back wrong");

   a_rd_left_low: assert property (@(posedge clk) disable iff (!arst_n)
      selLl |=> regRdData == $past(leftLow_ff))
      else $error("left dc low read back wrong");

   a_rd_right_high: assert property (@(posedge clk) disable iff (!arst_n)
      selRh |=> regRdData == {5'h00, $past(rightHigh_ff)})
      else $error("right dc high read back wrong");

   a_rd_right_low: assert property (@(posedge clk) disable iff (!arst_n)
      selRl |=> regRdData == $past(rightLow_ff))
      else $error("right dc low read back wrong");

   a_rd_unmapped: assert property (@(posedge clk) disable iff (!arst_n)
      !(selGains || selLh || selLl || selRh || selRl) |=> regRdData == 8'h00)
      else $error("unmapped read not zero");

   a_sel_onehot: assert property (@(posedge clk) disable iff (!arst_n)
      $onehot0({selGains, selLh, selLl, selRh, selRl}))
      else $error("address decode overlaps");

   // registers hold unless their own address is written
   a_gains_idle: assert property (@(posedge clk) disable iff (!arst_n)
      !regWrEn |=> $stable(gains_ff))
      else $error("gains changed without write");

   a_gains_other: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && !selGains |=> $stable(gains_ff))
      else $error("gains changed by other address");

   a_lh_idle: assert property (@(posedge clk) disable iff (!arst_n)
      !regWrEn |=> $stable(leftHigh_ff))
      else $error("left dc high changed without write");

   a_lh_other: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && !selLh |=> $stable(leftHigh_ff))
      else $error("left dc high changed by other address");

   a_ll_idle: assert property (@(posedge clk) disable iff (!arst_n)
      !regWrEn |=> $stable(leftLow_ff))
      else $error("left dc low changed without write");

   a_ll_other: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && !selLl |=> $stable(leftLow_ff))
      else $error("left dc low changed by other address");

   a_rh_idle: assert property (@(posedge clk) disable iff (!arst_n)
      !regWrEn |=> $stable(rightHigh_ff))
      else $error("right dc high changed without write");

   a_rh_other: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && !selRh |=> $stable(rightHigh_ff))
      else $error("right dc high changed by other address");

   a_rl_idle: assert property (@(posedge clk) disable iff (!arst_n)
      !regWrEn |=> $stable(rightLow_ff))
      else $error("right dc low changed without write");

   a_rl_other: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && !selRl |=> $stable(rightLow_ff))
      else $error("right dc low changed by other address");

   // each dc byte lands on its own
   a_left_low_pair: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && selLl |=> leftIf.dcValue[7:0] == $past(regWrData))
      else $error("left dc low bits not paired");

   a_right_high_pair: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && selRh |=> rightIf.dcValue[10:8] == $past(regWrData[2:0]))
      else $error("right dc high bits not paired");

   a_right_low_pair: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && selRl |=> rightIf.dcValue[7:0] == $past(regWrData))
      else $error("right dc low bits not paired");

   a_gain_write: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && selGains |=> leftAcGain == $past(regWrData[7:6]))
      else $error("left ac gain not written");
   a_right_ac_write: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && selGains |=> rightAcGain == $past(regWrData[5:4]))
      else $error("right ac gain not written");
   a_left_match_write: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && selGains |=> leftMatchGain == $past(regWrData[3:2]))
      else $error("left matching gain not written");
   a_right_match_write: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && selGains |=> rightMatchGain == $past(regWrData[1:0]))
      else $error("right matching gain not written");
   a_dc_high_pair: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && selLh |=> leftIf.dcValue[10:8] == $past(regWrData[2:0]))
      else $error("dc high bits not paired");
endmodule

// ---- dpd_pkg.sv ----
package dpd_pkg;
   localparam int RegAddrW = 8;
   localparam int RegDataW = 8;
   localparam int DcW = 11;
   localparam int DcHighW = 3;
   localparam int DcLowW = 8;
   localparam int ModW = 24;
   // 1.0 in Q0.11 equals 1/32 of full scale: 2^-5 * 2^-11 -> lsb at bit (ModW-1)-5-11
   localparam int DcLsbPos = ModW - 1 - 5 - DcW;
   localparam logic [RegAddrW-1:0] AddrGains = 8'h43;
   localparam logic [RegAddrW-1:0] AddrLeftDcHigh = 8'h44;
   localparam logic [RegAddrW-1:0] AddrLeftDcLow = 8'h45;
   localparam logic [RegAddrW-1:0] AddrRightDcHigh = 8'h46;
   localparam logic [RegAddrW-1:0] AddrRightDcLow = 8'h47;
   localparam logic [RegDataW-1:0] ResetGains = 8'h00;
   localparam logic [RegDataW-1:0] ResetDc = 8'h00;
   localparam int LeftAcPos = 6;
   localparam int RightAcPos = 4;
   localparam int LeftMatchPos = 2;
   localparam int RightMatchPos = 0;
   typedef enum logic [1:0] {AcGainEighth, AcGainQuarter, AcGainRsvd2, AcGainRsvd3} dpd_ac_gain_t;
   typedef enum logic [1:0] {MatchGainHalf, MatchGainOne, MatchRsvd2, MatchRsvd3} dpd_match_gain_t;
endpackage

// ---- dpd_chan_if.sv ----
`timescale 1ns/1ns
interface dpd_chan_if;
   logic [1:0] acGain;
   logic [1:0] matchGain;
   logic [10:0] dcValue;
   logic [23:0] modIn;
   logic [23:0] modOut;
   modport cfg (output acGain, output matchGain, output dcValue, output modIn, input modOut);
   modport chan (input acGain, input matchGain, input dcValue, input modIn, output modOut);
endinterface

// ---- dpd_chan_inject.sv ----
`timescale 1ns/1ns
module dpd_chan_inject (
   input wire clk,
   input wire arst_n,
   dpd_chan_if.chan ch
);
   logic [dpd_pkg::ModW-1:0] dcAligned;
   logic [dpd_pkg::ModW-1:0] modOut_ff;
   // zero dc value leaves the path untouched
   // explicit zero fill: a shifted 11-bit value would lose its top bits
   assign dcAligned = {{(dpd_pkg::ModW - dpd_pkg::DcW - dpd_pkg::DcLsbPos){1'b0}},
                       ch.dcValue, {dpd_pkg::DcLsbPos{1'b0}}};
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         modOut_ff <= '0;
      end else begin
         modOut_ff <= ch.modIn + dcAligned;
      end
   end
   assign ch.modOut = modOut_ff;
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ns
module testbench;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic regWrEn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic [23:0] leftModIn = 24'h100000;
   logic [23:0] rightModIn = 24'h012345;
   logic [7:0] regRdData;
   logic [23:0] leftModOut, rightModOut;
   logic [1:0] leftAcGain, rightAcGain, leftMatchGain, rightMatchGain;
   int fail_count = 0;
   int checks = 0;
   logic [7:0] codes [4] = '{8'h55, 8'h44, 8'h11, 8'h00};
   always #2 clk = ~clk;
   dpd_primary_dither uut (.clk(clk), .arst_n(arst_n), .regWrEn(regWrEn), .regAddr(regAddr),
      .regWrData(regWrData), .regRdData(regRdData), .leftModIn(leftModIn),
      .rightModIn(rightModIn), .leftModOut(leftModOut), .rightModOut(rightModOut),
      .leftAcGain(leftAcGain), .rightAcGain(rightAcGain), .leftMatchGain(leftMatchGain),
      .rightMatchGain(rightMatchGain));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // a spare edge after each write keeps the strobe from toggling twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      @(posedge clk);
      #1 regWrEn = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      regAddr = a;
      @(posedge clk);
      #1 chk({16'h0000, regRdData}, {16'h0000, exp});
   endtask
   task automatic gains(input logic [7:0] exp);
      chk({16'h0000, leftAcGain, rightAcGain, leftMatchGain, rightMatchGain}, {16'h0000, exp});
   endtask
   // dc lsb sits 11 places below the 1/32 point (bit 18) of the 24-bit path
   task automatic mod(input logic [10:0] l, input logic [10:0] r);
      @(posedge clk);
      #1 chk(leftModOut, leftModIn + ({13'h0000, l} << dpd_pkg::DcLsbPos));
      chk(rightModOut, rightModIn + ({13'h0000, r} << dpd_pkg::DcLsbPos));
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #20000;
      fail_count++;
      conclude();
   end
   initial begin
      repeat (2) @(posedge clk);
      #1 arst_n = 1'b1;
      for (int i = 0; i < 5; i++) rd(8'h43 + 8'(i), 8'h00);
      gains(8'h00);
      mod(11'h000, 11'h000);
      $display("reset values done");
      foreach (codes[i]) begin
         wr(8'h43, codes[i]);
         gains(codes[i]);
         rd(8'h43, codes[i]);
      end
      $display("gain codes done");
      wr(8'h44, 8'hff);
      rd(8'h44, 8'h07);
      wr(8'h45, 8'h01);
      mod(11'h701, 11'h000);
      wr(8'h46, 8'h02);
      wr(8'h47, 8'hff);
      mod(11'h701, 11'h2ff);
      rd(8'h47, 8'hff);
      $display("dc dither done");
      wr(8'h48, 8'h5a);
      rd(8'h48, 8'h00);
      rd(8'h42, 8'h00);
      gains(8'h00);
      for (int i = 1; i < 5; i++) wr(8'h43 + 8'(i), 8'h00);
      mod(11'h000, 11'h000);
      wr(8'h45, 8'h01);
      wr(8'h47, 8'h01);
      mod(11'h001, 11'h001);
      wr(8'h44, 8'h04);
      wr(8'h46, 8'h07);
      wr(8'h47, 8'hff);
      mod(11'h401, 11'h7ff);
      $display("unmapped and zero done");
      conclude();
   end
endmodule
